// ===== shared/kmc_pkg.sv
// shared constants and types of the keyboard and mouse controller host port
package kmc_pkg;
	// ****************************************
	// host port addresses
	// ****************************************
	localparam logic [7:0] ADDR_DATA = 8'h60;
	localparam logic [7:0] ADDR_CMD = 8'h64;
	// ****************************************
	// command codes
	// ****************************************
	localparam logic [7:0] CMD_RD_CCB = 8'h20;
	localparam logic [7:0] CMD_WR_CCB = 8'h60;
	localparam logic [7:0] CMD_AUX_DIS = 8'hA7;
	localparam logic [7:0] CMD_AUX_EN = 8'hA8;
	localparam logic [7:0] CMD_AUX_TEST = 8'hA9;
	localparam logic [7:0] CMD_SELF_TEST = 8'hAA;
	localparam logic [7:0] CMD_KBD_TEST = 8'hAB;
	localparam logic [7:0] CMD_KBD_DIS = 8'hAD;
	localparam logic [7:0] CMD_KBD_EN = 8'hAE;
	localparam logic [7:0] CMD_RD_INPORT = 8'hC0;
	localparam logic [7:0] CMD_POLL_LO = 8'hC1;
	localparam logic [7:0] CMD_POLL_HI = 8'hC2;
	localparam logic [7:0] CMD_RD_SCRATCH = 8'hCA;
	localparam logic [7:0] CMD_WR_SCRATCH = 8'hCB;
	localparam logic [7:0] CMD_RD_OUTPORT = 8'hD0;
	localparam logic [7:0] CMD_WR_GATE = 8'hD1;
	localparam logic [7:0] CMD_ECHO_KBD = 8'hD2;
	localparam logic [7:0] CMD_ECHO_AUX = 8'hD3;
	localparam logic [7:0] CMD_TO_AUX = 8'hD4;
	localparam logic [3:0] CMD_PULSE_GRP = 4'hF;
	// ****************************************
	// reply codes
	// ****************************************
	localparam logic [7:0] SELF_TEST_OK = 8'h55;
	localparam logic [7:0] TEST_OK = 8'h00;
	localparam logic [7:0] TEST_CLK_LO = 8'h01;
	localparam logic [7:0] TEST_CLK_HI = 8'h02;
	localparam logic [7:0] TEST_DAT_LO = 8'h03;
	localparam logic [7:0] TEST_DAT_HI = 8'h04;
	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int CCB_KBD_IE = 0;
	localparam int CCB_AUX_IE = 1;
	localparam int CCB_SYS = 2;
	localparam int CCB_KBD_DIS = 4;
	localparam int CCB_AUX_DIS = 5;
	localparam logic [7:0] CCB_WR_MASK = 8'h77;
	localparam logic [7:0] CCB_RESET = 8'h00;
	localparam logic [7:0] SCRATCH_RESET = 8'h00;
	localparam logic [3:0] FRAME_STOP = 4'hA;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_KHZ = 10000;
	localparam int RST_PULSE_NS = 6000;
	localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_KHZ + 999999) / 1000000;
	localparam int TIMEOUT_US = 2000;
	localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_KHZ / 1000;
	localparam logic [2:0] TEST_SETTLE_CYC = 3'h4;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PARAM = 3'b010,
		ST_TEST = 3'b100
	} kmc_state_e;
endpackage

// ===== core/kmc_link_rx.sv
// serial frame receiver on the link clock with odd parity check
`timescale 1ns/1ns
`default_nettype none
module kmc_link_rx (
	input wire logic link_clk, // link clock, data taken on falling edge
	input wire logic rst, // reset from the core domain
	input wire logic link_data, // serial data line
	output logic [7:0] byte_q, // last received byte
	output logic perr_q, // parity of last byte was wrong
	output logic done_tg_q, // toggles once per received frame
	output logic busy_q // frame in progress
);
	import kmc_pkg::*;
	logic rst_s1_q, rst_s2_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic par_q;
	always_ff @(negedge link_clk) begin
		rst_s1_q <= rst;
		rst_s2_q <= rst_s1_q;
	end
	always_ff @(negedge link_clk) begin
		if (rst_s2_q) begin
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			par_q <= 1'b0;
			byte_q <= 8'h00;
			perr_q <= 1'b0;
			done_tg_q <= 1'b0;
			busy_q <= 1'b0;
		end else if (cnt_q == 4'h0) begin
			if (!link_data) begin
				cnt_q <= 4'h1;
				busy_q <= 1'b1;
			end
		end else if (cnt_q == FRAME_STOP) begin
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
			byte_q <= sh_q;
			perr_q <= ~(^sh_q ^ par_q);
			done_tg_q <= ~done_tg_q;
		end else begin
			if (cnt_q == 4'h9) begin
				par_q <= link_data;
			end else begin
				sh_q <= {link_data, sh_q[7:1]};
			end
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule // kmc_link_rx
`default_nettype wire

// ===== core/kmc_rst_pulse.sv
// fixed-length low pulse on the processor reset line
`timescale 1ns/1ns
`default_nettype none
module kmc_rst_pulse (
	input wire logic clk, // core clock
	input wire logic rst, // synchronous reset
	input wire logic go, // one-cycle start request
	output logic line_n_q // reset line, low during pulse
);
	import kmc_pkg::*;
	logic [6:0] cnt_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= 7'h00;
			line_n_q <= 1'b1;
		end else if (go && line_n_q) begin
			cnt_q <= 7'(RST_PULSE_CYC - 1);
			line_n_q <= 1'b0;
		end else if (cnt_q != 7'h00) begin
			cnt_q <= cnt_q - 7'h01;
		end else begin
			line_n_q <= 1'b1;
		end
	end
endmodule // kmc_rst_pulse
`default_nettype wire

// ===== core/kmc_host_port.sv
// keyboard and mouse controller: host data and command ports
// Operation
// - check parity, present received byte to host
// - raise interrupt when output buffer loads
// - output buffer is read-only at 60h
// - 60h write is data, 64h write command
// - host writes only when input buffer empty
// - status at 64h, full flags, command flag
// - status inhibit, mouse full, timeout, parity bits
// - status bit 2 follows system flag
// - 20h reads, 60h writes command byte
// - A7h disables, A8h enables mouse interface
// - A9h tests mouse lines, returns code
// - AAh self-test returns 55h
// - ABh tests keyboard lines, returns code
// - ADh disables, AEh enables keyboard interface
// - C0h returns controller input port
// - C1h/C2h copy input nibble into status
// - CBh stores scratch byte, CAh returns it
// - D0h returns controller output port
// - D1h sets address gate from bit 1
// - D2h/D3h echo byte as keyboard/mouse
// - D4h forwards next data byte to mouse
// - FEh pulses reset line low briefly
`timescale 1ns/1ns
`default_nettype none
module kmc_host_port #(
	parameter int TIMEOUT_CYCLES = kmc_pkg::TIMEOUT_CYC // frame time-out in clk cycles
) (
	input wire logic clk, // core clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [7:0] io_addr, // host port address
	input wire logic io_rd, // host read strobe
	input wire logic io_wr, // host write strobe
	input wire logic [7:0] io_wdata, // host write data
	output logic [7:0] io_rdata, // host read data
	input wire logic kbd_clk_i, // keyboard link clock
	output logic kbd_clk_o, // keyboard clock drive level
	output logic kbd_clk_oe, // keyboard clock drive enable
	input wire logic kbd_data_i, // keyboard data line
	output logic kbd_data_o, // keyboard data drive level
	output logic kbd_data_oe, // keyboard data drive enable
	input wire logic mouse_clk_i, // mouse link clock
	output logic mouse_clk_o, // mouse clock drive level
	output logic mouse_clk_oe, // mouse clock drive enable
	input wire logic mouse_data_i, // mouse data line
	output logic mouse_data_o, // mouse data drive level
	output logic mouse_data_oe, // mouse data drive enable
	output logic [7:0] kbd_tx_data, // byte for the keyboard
	output logic kbd_tx_valid, // keyboard byte strobe
	output logic [7:0] mouse_tx_data, // byte for the mouse
	output logic mouse_tx_valid, // mouse byte strobe
	output logic kbd_irq, // keyboard interrupt
	output logic mouse_irq, // mouse interrupt
	input wire logic [7:0] controller_input_port, // input port pins
	output logic high_address_gate, // address gate line
	output logic processor_reset_line_n // processor reset, low active
);
	import kmc_pkg::*;
	// ****************************************
	// declarations
	// ****************************************
	kmc_state_e st_q;
	logic [7:0] ib_q, ob_q, ccb_q, scratch_q, pcmd_q, inp_s1_q, inp_s2_q, status, outport, rep_b;
	logic ibf_q, cmd_q, obf_q, aux_obf_q, perr_q, tmo_q, gate_q, tsel_q;
	logic [1:0] poll_q, pend_q, pend_perr_q, ln_clk, ln_dat, clk_oe_q, dat_oe_q;
	logic [1:0] lk_clk, lk_dat, dis, tg_s3_q, evt;
	logic [7:0] pend_b_q [2];
	logic [7:0] rx_b [2];
	logic [1:0] rx_perr, rx_tg, rx_busy, tg_s1_q, tg_s2_q, bz_s1_q, bz_s2_q;
	logic [1:0] ls1_clk_q, ls2_clk_q, ls1_dat_q, ls2_dat_q;
	logic [1:0] tstep_q;
	logic [2:0] tcnt_q;
	logic [7:0] tres_q;
	logic tdrv_clk_q, tdrv_dat_q, test_done, needs, rep_aux, take_ib, rep_v, ld_kbd, ld_aux, pulse_go;
	logic [15:0] tmo_cnt_q;
	logic [7:0] kbd_tx_q, aux_tx_q, rdata_q;
	logic kbd_txv_q, aux_txv_q, kbd_irq_q, aux_irq_q;
	assign lk_clk = {mouse_clk_i, kbd_clk_i};
	assign lk_dat = {mouse_data_i, kbd_data_i};
	assign dis = {ccb_q[CCB_AUX_DIS], ccb_q[CCB_KBD_DIS]};
	// ****************************************
	// link receivers and crossings
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_ch
			kmc_link_rx u_rx (
				.link_clk(lk_clk[i]),
				.rst(rst),
				.link_data(lk_dat[i]),
				.byte_q(rx_b[i]),
				.perr_q(rx_perr[i]),
				.done_tg_q(rx_tg[i]),
				.busy_q(rx_busy[i])
			);
			always_ff @(posedge clk) begin
				tg_s1_q[i] <= rx_tg[i];
				tg_s2_q[i] <= tg_s1_q[i];
				bz_s1_q[i] <= rx_busy[i];
				bz_s2_q[i] <= bz_s1_q[i];
				ls1_clk_q[i] <= lk_clk[i];
				ls2_clk_q[i] <= ls1_clk_q[i];
				ls1_dat_q[i] <= lk_dat[i];
				ls2_dat_q[i] <= ls1_dat_q[i];
			end
			assign ln_clk[i] = ls2_clk_q[i];
			assign ln_dat[i] = ls2_dat_q[i];
			assign evt[i] = tg_s2_q[i] ^ tg_s3_q[i];
			always_ff @(posedge clk) begin
				if (rst) begin
					tg_s3_q[i] <= 1'b0;
					pend_q[i] <= 1'b0;
					pend_perr_q[i] <= 1'b0;
					pend_b_q[i] <= 8'h00;
				end else begin
					tg_s3_q[i] <= tg_s2_q[i];
					if (evt[i] && !dis[i]) begin
						pend_q[i] <= 1'b1;
						pend_perr_q[i] <= rx_perr[i];
						pend_b_q[i] <= rx_b[i];
					end else if ((i == 0) ? ld_kbd : ld_aux) begin
						pend_q[i] <= 1'b0;
					end
				end
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					clk_oe_q[i] <= 1'b0;
					dat_oe_q[i] <= 1'b0;
				end else if (st_q == ST_TEST && tsel_q == 1'(i)) begin
					clk_oe_q[i] <= tdrv_clk_q;
					dat_oe_q[i] <= tdrv_dat_q;
				end else begin
					clk_oe_q[i] <= dis[i];
					dat_oe_q[i] <= 1'b0;
				end
			end
		end
	endgenerate
	// ****************************************
	// host writes into the input buffer
	// ****************************************
	// data or command flag
	always_ff @(posedge clk) begin
		if (rst) begin
			ib_q <= 8'h00;
			ibf_q <= 1'b0;
			cmd_q <= 1'b0;
		end else if (io_wr && !ibf_q && (io_addr == ADDR_DATA || io_addr == ADDR_CMD)) begin
			ib_q <= io_wdata;
			ibf_q <= 1'b1;
			cmd_q <= (io_addr == ADDR_CMD);
		end else if (take_ib) begin
			ibf_q <= 1'b0;
		end
	end
	// ****************************************
	// command decode and replies
	// ****************************************
	assign outport = {2'b00, aux_obf_q, obf_q & ~aux_obf_q, 2'b00, gate_q, processor_reset_line_n};
	always_comb begin
		needs = 1'b0;
		rep_b = ib_q;
		rep_aux = 1'b0;
		if (cmd_q) begin
			needs = 1'b1;
			case (ib_q)
				CMD_RD_CCB: rep_b = ccb_q;
				CMD_SELF_TEST: rep_b = SELF_TEST_OK;
				CMD_RD_INPORT: rep_b = inp_s2_q;
				CMD_RD_SCRATCH: rep_b = scratch_q;
				CMD_RD_OUTPORT: rep_b = outport;
				CMD_AUX_TEST, CMD_KBD_TEST: needs = 1'b1;
				default: needs = 1'b0;
			endcase
		end else if (st_q == ST_PARAM && (pcmd_q == CMD_ECHO_KBD || pcmd_q == CMD_ECHO_AUX)) begin
			needs = 1'b1;
			rep_aux = (pcmd_q == CMD_ECHO_AUX);
		end
	end
	assign take_ib = ibf_q && st_q != ST_TEST && !(needs && obf_q);
	assign rep_v = take_ib && needs && !(cmd_q && (ib_q == CMD_AUX_TEST || ib_q == CMD_KBD_TEST));
	assign test_done = (st_q == ST_TEST) && (tstep_q == 2'h3);
	assign ld_kbd = !rep_v && !test_done && !obf_q && st_q == ST_IDLE && !ibf_q && pend_q[0];
	assign ld_aux = !rep_v && !test_done && !obf_q && st_q == ST_IDLE && !ibf_q && !pend_q[0] && pend_q[1];
	assign pulse_go = take_ib && cmd_q && ib_q[7:4] == CMD_PULSE_GRP && !ib_q[0];
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= ST_IDLE;
			pcmd_q <= 8'h00;
			ccb_q <= CCB_RESET;
			scratch_q <= SCRATCH_RESET;
			gate_q <= 1'b0;
			poll_q <= 2'b00;
			tsel_q <= 1'b0;
			kbd_tx_q <= 8'h00;
			aux_tx_q <= 8'h00;
			kbd_txv_q <= 1'b0;
			aux_txv_q <= 1'b0;
		end else begin
			kbd_txv_q <= 1'b0;
			aux_txv_q <= 1'b0;
			if (test_done) begin
				st_q <= ST_IDLE;
			end else if (take_ib && cmd_q) begin
				st_q <= ST_IDLE;
				poll_q <= 2'b00;
				unique case (ib_q)
					CMD_WR_CCB, CMD_WR_SCRATCH, CMD_WR_GATE, CMD_ECHO_KBD, CMD_ECHO_AUX, CMD_TO_AUX: begin
						st_q <= ST_PARAM;
						pcmd_q <= ib_q;
					end
					CMD_AUX_DIS: ccb_q[CCB_AUX_DIS] <= 1'b1;
					CMD_AUX_EN: ccb_q[CCB_AUX_DIS] <= 1'b0;
					CMD_KBD_DIS: ccb_q[CCB_KBD_DIS] <= 1'b1;
					CMD_KBD_EN: ccb_q[CCB_KBD_DIS] <= 1'b0;
					CMD_POLL_LO: poll_q <= 2'b01;
					CMD_POLL_HI: poll_q <= 2'b10;
					CMD_AUX_TEST: begin
						st_q <= ST_TEST;
						tsel_q <= 1'b1;
					end
					CMD_KBD_TEST: begin
						st_q <= ST_TEST;
						tsel_q <= 1'b0;
					end
					default: st_q <= ST_IDLE;
				endcase
			end else if (take_ib && st_q == ST_PARAM) begin
				st_q <= ST_IDLE;
				unique case (pcmd_q)
					CMD_WR_CCB: ccb_q <= ib_q & CCB_WR_MASK;
					CMD_WR_SCRATCH: scratch_q <= ib_q;
					CMD_WR_GATE: gate_q <= ib_q[1];
					CMD_TO_AUX: begin
						aux_tx_q <= ib_q;
						aux_txv_q <= 1'b1;
					end
					default: st_q <= ST_IDLE;
				endcase
			end else if (take_ib) begin
				kbd_tx_q <= ib_q;
				kbd_txv_q <= 1'b1;
			end
		end
	end
	// ****************************************
	// interface line test
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst || st_q != ST_TEST) begin
			tstep_q <= 2'h0;
			tcnt_q <= 3'h0;
			tres_q <= TEST_OK;
			tdrv_clk_q <= 1'b0;
			tdrv_dat_q <= 1'b0;
		end else if (tstep_q != 2'h3) begin
			if (tcnt_q != TEST_SETTLE_CYC) begin
				tcnt_q <= tcnt_q + 3'h1;
			end else begin
				tcnt_q <= 3'h0;
				tstep_q <= tstep_q + 2'h1;
				if (tres_q == TEST_OK) begin
					unique case (tstep_q)
						2'h0: begin
							if (!ln_clk[tsel_q]) begin
								tres_q <= TEST_CLK_LO;
							end else if (!ln_dat[tsel_q]) begin
								tres_q <= TEST_DAT_LO;
							end
						end
						2'h1: begin
							if (ln_clk[tsel_q]) begin
								tres_q <= TEST_CLK_HI;
							end
						end
						default: begin
							if (ln_dat[tsel_q]) begin
								tres_q <= TEST_DAT_HI;
							end
						end
					endcase
				end
				tdrv_clk_q <= (tstep_q == 2'h0);
				tdrv_dat_q <= (tstep_q == 2'h1);
			end
		end
	end
	// ****************************************
	// output buffer, status and time-out
	// ****************************************
	// output buffer loading
	always_ff @(posedge clk) begin
		if (rst) begin
			ob_q <= 8'h00;
			obf_q <= 1'b0;
			aux_obf_q <= 1'b0;
			perr_q <= 1'b0;
		end else if (rep_v) begin
			ob_q <= rep_b;
			obf_q <= 1'b1;
			aux_obf_q <= rep_aux;
		end else if (test_done) begin
			ob_q <= tres_q;
			obf_q <= 1'b1;
			aux_obf_q <= 1'b0;
		end else if (ld_kbd || ld_aux) begin
			ob_q <= ld_kbd ? pend_b_q[0] : pend_b_q[1];
			obf_q <= 1'b1;
			aux_obf_q <= ld_aux;
			perr_q <= ld_kbd ? pend_perr_q[0] : pend_perr_q[1];
		end else if (io_rd && io_addr == ADDR_DATA) begin
			obf_q <= 1'b0;
			aux_obf_q <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			tmo_cnt_q <= 16'h0000;
			tmo_q <= 1'b0;
		end else begin
			if (bz_s2_q == 2'b00) begin
				tmo_cnt_q <= 16'h0000;
			end else if (tmo_cnt_q != 16'(TIMEOUT_CYCLES - 1)) begin
				tmo_cnt_q <= tmo_cnt_q + 16'h0001;
			end
			if (bz_s2_q != 2'b00 && tmo_cnt_q == 16'(TIMEOUT_CYCLES - 1)) begin
				tmo_q <= 1'b1;
			end else if (ld_kbd || ld_aux) begin
				tmo_q <= 1'b0;
			end
		end
	end
	always_comb begin
		status = {perr_q, tmo_q, aux_obf_q, ~ccb_q[CCB_KBD_DIS], cmd_q, ccb_q[CCB_SYS], ibf_q, obf_q};
		if (poll_q[0]) begin
			status[7:4] = inp_s2_q[3:0];
		end else if (poll_q[1]) begin
			status[7:4] = inp_s2_q[7:4];
		end
	end
	always_ff @(posedge clk) begin
		inp_s1_q <= controller_input_port;
		inp_s2_q <= inp_s1_q;
		if (rst) begin
			rdata_q <= 8'h00;
			kbd_irq_q <= 1'b0;
			aux_irq_q <= 1'b0;
		end else begin
			if (io_rd) begin
				rdata_q <= (io_addr == ADDR_DATA) ? ob_q : (io_addr == ADDR_CMD) ? status : 8'h00;
			end
			kbd_irq_q <= obf_q && !aux_obf_q && ccb_q[CCB_KBD_IE];
			aux_irq_q <= obf_q && aux_obf_q && ccb_q[CCB_AUX_IE];
		end
	end
	kmc_rst_pulse u_rst (
		.clk(clk),
		.rst(rst),
		.go(pulse_go),
		.line_n_q(processor_reset_line_n)
	);
	assign io_rdata = rdata_q;
	assign kbd_clk_o = 1'b0;
	assign kbd_data_o = 1'b0;
	assign mouse_clk_o = 1'b0;
	assign mouse_data_o = 1'b0;
	assign kbd_clk_oe = clk_oe_q[0];
	assign kbd_data_oe = dat_oe_q[0];
	assign mouse_clk_oe = clk_oe_q[1];
	assign mouse_data_oe = dat_oe_q[1];
	assign kbd_tx_data = kbd_tx_q;
	assign kbd_tx_valid = kbd_txv_q;
	assign mouse_tx_data = aux_tx_q;
	assign mouse_tx_valid = aux_txv_q;
	assign kbd_irq = kbd_irq_q;
	assign mouse_irq = aux_irq_q;
	assign high_address_gate = gate_q;
endmodule // kmc_host_port
`default_nettype wire

// ===== testbench/kmc_host_port_props.sv
// concurrent checks on the host port pins
`timescale 1ns/1ns
`default_nettype none
module kmc_host_port_props #(
	parameter int TIMEOUT_CYCLES = kmc_pkg::TIMEOUT_CYC // frame time-out
) (
	input wire logic clk, // core clock
	input wire logic rst, // reset
	input wire logic [7:0] io_addr, // address
	input wire logic io_rd, // read strobe
	input wire logic io_wr, // write strobe
	input wire logic [7:0] io_wdata, // write data
	input wire logic [7:0] io_rdata, // read data
	input wire logic kbd_clk_oe, // kbd clock pull
	input wire logic [7:0] kbd_tx_data, // kbd byte
	input wire logic kbd_tx_valid, // kbd strobe
	input wire logic [7:0] mouse_tx_data, // mouse byte
	input wire logic mouse_tx_valid, // mouse strobe
	input wire logic kbd_irq, // kbd interrupt
	input wire logic mouse_irq, // mouse interrupt
	input wire logic high_address_gate, // gate line
	input wire logic processor_reset_line_n // reset line
);
	import kmc_pkg::*;
	logic [7:0] cmd_q;
	logic [7:0] dat_q;
	int lo_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ****
	// last host bytes, low pulse length
	// ****
	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_q <= 8'h00;
			dat_q <= 8'h00;
		end else if (io_wr && io_addr == ADDR_CMD)
			cmd_q <= io_wdata;
		else if (io_wr && io_addr == ADDR_DATA)
			dat_q <= io_wdata;
	end
	always_ff @(posedge clk) begin
		if (rst || processor_reset_line_n)
			lo_q <= 0;
		else
			lo_q <= lo_q + 1;
	end
	// ****
	// properties
	// ****
	property p_unmapped;
		io_rd && io_addr != ADDR_DATA && io_addr != ADDR_CMD |=> io_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_hold;
		!io_rd |=> $stable(io_rdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved without a read");
	property p_irq_one;
		!(kbd_irq && mouse_irq);
	endproperty
	a_irq_one: assert property (p_irq_one) else $error("both interrupts high");
	property p_kbd_tx;
		kbd_tx_valid |-> kbd_tx_data == dat_q ##1 !kbd_tx_valid;
	endproperty
	a_kbd_tx: assert property (p_kbd_tx) else $error("keyboard byte wrong");
	property p_mouse_tx;
		mouse_tx_valid |-> mouse_tx_data == dat_q && cmd_q == CMD_TO_AUX ##1 !mouse_tx_valid;
	endproperty
	a_mouse_tx: assert property (p_mouse_tx) else $error("mouse byte wrong");
	property p_gate;
		$changed(high_address_gate) |-> cmd_q == CMD_WR_GATE && high_address_gate == dat_q[1];
	endproperty
	a_gate: assert property (p_gate) else $error("gate changed wrongly");
	property p_kbd_dis;
		io_wr && io_addr == ADDR_CMD && io_wdata == CMD_KBD_DIS |-> ##[1:6] kbd_clk_oe;
	endproperty
	a_kbd_dis: assert property (p_kbd_dis) else $error("keyboard clock not held");
	property p_pulse_even;
		$fell(processor_reset_line_n) |-> cmd_q[7:4] == CMD_PULSE_GRP && !cmd_q[0];
	endproperty
	a_pulse_even: assert property (p_pulse_even) else $error("reset pulse without command");
	property p_pulse_len;
		$rose(processor_reset_line_n) |-> lo_q == RST_PULSE_CYC;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
	c_pulse: cover property ($fell(processor_reset_line_n));
	c_gate: cover property ($rose(high_address_gate));
	c_mtx: cover property (mouse_tx_valid);
	c_mirq: cover property ($rose(mouse_irq));
endmodule // kmc_host_port_props
bind kmc_host_port kmc_host_port_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (.clk(clk), .rst(rst),
	.io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
	.kbd_clk_oe(kbd_clk_oe), .kbd_tx_data(kbd_tx_data), .kbd_tx_valid(kbd_tx_valid),
	.mouse_tx_data(mouse_tx_data), .mouse_tx_valid(mouse_tx_valid), .kbd_irq(kbd_irq),
	.mouse_irq(mouse_irq), .high_address_gate(high_address_gate),
	.processor_reset_line_n(processor_reset_line_n));
`default_nettype wire

// ===== testbench/kmc_link_dev.sv
// keyboard or mouse device sending frames on its own clock
`timescale 1ns/1ns
`default_nettype none
module kmc_link_dev (
	input wire logic stuck, // hold clock line low
	output logic clk_lo, // pull clock line low
	output logic dat_lo // pull data line low
);
	logic gen;
	initial begin
		gen = 1'b1;
		dat_lo = 1'b0;
	end
	assign clk_lo = stuck | ~gen;
	// clock runs only inside frames; data changes while clock is high
	task automatic pulses(input int n, input logic [10:0] f);
		for (int i = 0; i < n; i++) begin
			dat_lo = ~f[i];
			#7 gen = 1'b0;
			#8 gen = 1'b1;
		end
		dat_lo = 1'b0;
	endtask
	task automatic send(input logic [7:0] b, input logic good);
		pulses(11, {1'b1, (^b) ^ good, b, 1'b0});
	endtask
endmodule // kmc_link_dev
`default_nettype wire

// ===== testbench/tb_keyboard_mouse_controller_host_port.sv
// self-checking bench for the host port
`timescale 1ns/1ns
`default_nettype none
module tb_keyboard_mouse_controller_host_port;
	import kmc_pkg::*;
	typedef struct packed {logic [7:0] c; logic hp; logic [7:0] p; logic hr; logic [7:0] r;} kmc_row_s;
	logic clk, rst, rd, wr, kco, kdo, mco, mdo, kcoe, kdoe, mcoe, mdoe, ktv, mtv, kirq, mirq, gate, rln, mstk;
	logic [7:0] addr, wd, rdata, inp, ktd, mtd, got, ktx, mtx, s;
	logic [1:0] irq;
	logic k_cl, k_dl, m_cl, m_dl;
	wire kc, kd, mc, md;
	int error_cnt, check_count, lo, n0;
	kmc_row_s rows [12];
	// open-drain lines with pull-ups
	assign kc = ~(k_cl | (kcoe & ~kco));
	assign kd = ~(k_dl | (kdoe & ~kdo));
	assign mc = ~(m_cl | (mcoe & ~mco));
	assign md = ~(m_dl | (mdoe & ~mdo));
	kmc_link_dev kdev (.stuck(1'b0), .clk_lo(k_cl), .dat_lo(k_dl));
	kmc_link_dev mdev (.stuck(mstk), .clk_lo(m_cl), .dat_lo(m_dl));
	kmc_host_port #(.TIMEOUT_CYCLES(50)) dut (.clk(clk), .rst(rst), .io_addr(addr), .io_rd(rd), .io_wr(wr),
		.io_wdata(wd), .io_rdata(rdata), .kbd_clk_i(kc), .kbd_clk_o(kco), .kbd_clk_oe(kcoe), .kbd_data_i(kd),
		.kbd_data_o(kdo), .kbd_data_oe(kdoe), .mouse_clk_i(mc), .mouse_clk_o(mco), .mouse_clk_oe(mcoe),
		.mouse_data_i(md), .mouse_data_o(mdo), .mouse_data_oe(mdoe), .kbd_tx_data(ktd), .kbd_tx_valid(ktv),
		.mouse_tx_data(mtd), .mouse_tx_valid(mtv), .kbd_irq(kirq), .mouse_irq(mirq), .controller_input_port(inp),
		.high_address_gate(gate), .processor_reset_line_n(rln));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (ktv)
			ktx <= ktd;
		if (mtv)
			mtx <= mtd;
		if (!rln)
			lo <= lo + 1;
	end
	// ****
	// tasks
	// ****
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdp(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		d = rdata;
	endtask
	// status once the input buffer is empty
	task automatic stat(output logic [7:0] d);
		d = 8'h02;
		for (int n = 0; n < 100 && d[1] !== 1'b0; n++)
			rdp(ADDR_CMD, d);
		if (d[1] !== 1'b0)
			error_cnt++;
	endtask
	task automatic wrp(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] t;
		stat(t);
		@(negedge clk);
		addr = a;
		wd = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic get(output logic [7:0] d, output logic [1:0] q, output logic [7:0] st);
		st = 8'h00;
		for (int n = 0; n < 100 && st[0] !== 1'b1; n++)
			rdp(ADDR_CMD, st);
		if (st[0] !== 1'b1)
			error_cnt++;
		@(negedge clk);
		q = {mirq, kirq};
		rdp(ADDR_DATA, d);
	endtask
	task automatic rst_seq();
		rst = 1'b1;
		kdev.pulses(4, 11'h7FF);
		mdev.pulses(4, 11'h7FF);
		repeat (5) @(negedge clk);
		rst = 1'b0;
		kdev.pulses(4, 11'h7FF);
		mdev.pulses(4, 11'h7FF);
		stat(s);
		check(s, 8'h10);
		check({6'h00, gate, rln}, 8'h01);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#2000000;
		error_cnt++;
		stop_test();
	end
	// ****
	// main sequence
	// ****
	initial begin
		{rd, wr, addr, wd, mstk} = '0;
		inp = 8'h3C;
		rows = '{'{CMD_WR_CCB, 1'b1, 8'h45, 1'b0, 8'h00}, '{CMD_RD_CCB, 1'b0, 8'h00, 1'b1, 8'h45},
			'{CMD_WR_SCRATCH, 1'b1, 8'hA5, 1'b0, 8'h00}, '{CMD_RD_SCRATCH, 1'b0, 8'h00, 1'b1, 8'hA5},
			'{CMD_SELF_TEST, 1'b0, 8'h00, 1'b1, 8'h55}, '{CMD_RD_INPORT, 1'b0, 8'h00, 1'b1, 8'h3C},
			'{CMD_ECHO_KBD, 1'b1, 8'h5A, 1'b1, 8'h5A}, '{CMD_ECHO_AUX, 1'b1, 8'h6B, 1'b1, 8'h6B},
			'{CMD_AUX_TEST, 1'b0, 8'h00, 1'b1, 8'h00}, '{CMD_KBD_TEST, 1'b0, 8'h00, 1'b1, 8'h00},
			'{CMD_WR_GATE, 1'b1, 8'h02, 1'b0, 8'h00}, '{CMD_RD_OUTPORT, 1'b0, 8'h00, 1'b1, 8'h03}};
		rst_seq();
		foreach (rows[i]) begin
			wrp(ADDR_CMD, rows[i].c);
			if (rows[i].hp)
				wrp(ADDR_DATA, rows[i].p);
			if (rows[i].hr) begin
				get(got, irq, s);
				check(got, rows[i].r);
			end
		end
		stat(s);
		check(s, 8'h1C);
		check({7'h00, gate}, 8'h01);
		kdev.send(8'hA3, 1'b1);
		get(got, irq, s);
		check(s, 8'h1D);
		check(got, 8'hA3);
		check({6'h00, irq}, 8'h01);
		kdev.send(8'h3C, 1'b0);
		get(got, irq, s);
		check(s, 8'h9D);
		wrp(ADDR_CMD, CMD_WR_CCB);
		wrp(ADDR_DATA, 8'h46);
		mdev.send(8'h81, 1'b1);
		get(got, irq, s);
		check(s, 8'h35);
		check(got, 8'h81);
		check({6'h00, irq}, 8'h02);
		wrp(ADDR_CMD, CMD_POLL_LO);
		stat(s);
		check(s, 8'hCC);
		wrp(ADDR_CMD, CMD_POLL_HI);
		stat(s);
		check(s, 8'h3C);
		wrp(ADDR_CMD, CMD_KBD_DIS);
		stat(s);
		check(s, 8'h0C);
		check({7'h00, kcoe}, 8'h01);
		wrp(ADDR_CMD, CMD_KBD_EN);
		stat(s);
		check(s, 8'h1C);
		wrp(ADDR_CMD, CMD_AUX_DIS);
		stat(s);
		check({7'h00, mcoe}, 8'h01);
		wrp(ADDR_CMD, CMD_AUX_EN);
		stat(s);
		check({7'h00, mcoe}, 8'h00);
		wrp(ADDR_CMD, CMD_TO_AUX);
		wrp(ADDR_DATA, 8'h77);
		wrp(ADDR_DATA, 8'hED);
		stat(s);
		check(mtx, 8'h77);
		check(ktx, 8'hED);
		n0 = lo;
		wrp(ADDR_CMD, 8'hF1);
		repeat (80) @(negedge clk);
		wrp(ADDR_CMD, 8'hFE);
		repeat (80) @(negedge clk);
		check(8'(lo - n0), 8'(RST_PULSE_CYC));
		mstk = 1'b1;
		wrp(ADDR_CMD, CMD_AUX_TEST);
		get(got, irq, s);
		mstk = 1'b0;
		check(got, TEST_CLK_LO);
		rdp(8'h61, got);
		check(got, 8'h00);
		mdev.pulses(4, 11'h000);
		repeat (60) @(negedge clk);
		stat(s);
		check(s, 8'h5C);
		rst_seq();
		stop_test();
	end
endmodule // tb_keyboard_mouse_controller_host_port
`default_nettype wire
